/* core/flash_config_error_ctrl.sv */
// Overview of operation
// - Command-done interrupt requested while enable and done flag set.
// - Config register: only four control bits writable; others read zero except bit 5, the erase-all status.
// - Erase-all status bit cannot be written by software.
// - Erase-all status sets on external request while command done.
// - Erase-all erases, verifies, programs security byte, then unsecures.
// - Erase-all status clears when the whole operation finishes.
// - Ignore-single-fault hides detected single faults and their interrupt, not forced ones.
// - Force-double-fault makes every array read set the double fault flag.
// - Force-double-fault stays set until software writes zero.
// - Force-single-fault makes every array read set the single flag.
// - Force-single-fault stays set until software writes zero.
// - Single-fault interrupt requested while its enable and flag are set.
// - Every implemented error-config bit is readable and writable.
// - Done flag reads one when finished; writing one starts a command.
// - Fault flags readable, cleared only by writing one.
`timescale 1ns/1ps
`include "flash_cfg_params.svh"
module flash_config_error_ctrl
  import flash_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic eraseAllReqPin,
  input wire logic arrayRead,
  input wire logic singleFaultDet,
  input wire logic doubleFaultDet,
  output logic cmdDoneIrq,
  output logic singleFaultIrq,
  output logic doubleFaultIrq,
  output logic irq,
  output logic [1:0] securityStateField,
  output logic securityProgram,
  output logic cmdBusy
);
  import flash_cfg_pkg::*;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Bus address phase capture
  logic wrPend_ff;
  logic rdPend_ff;
  logic [11:0] addr_ff;
  wire addrPhase = hsel & hready & htrans[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff <= 12'h000;
    end else begin
      wrPend_ff <= addrPhase & hwrite;
      rdPend_ff <= addrPhase & ~hwrite;
      if (addrPhase) addr_ff <= haddr[11:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wrCfg = wrPend_ff & hit(addr_ff, `OFS_FLASH_CONFIG);
  wire wrErrCfg = wrPend_ff & hit(addr_ff, `OFS_ERR_IRQ_CONFIG);
  wire wrStat = wrPend_ff & hit(addr_ff, `OFS_FLASH_STATUS);
  wire wrErrFlags = wrPend_ff & hit(addr_ff, `OFS_ERROR_FLAGS);
  wire wrIrqStat = wrPend_ff & hit(addr_ff, `OFS_IRQ_STATUS);
  wire wrIrqMask = wrPend_ff & hit(addr_ff, `OFS_IRQ_MASK);

  // Pin synchroniser, first stage read only by the second
  logic eraseSync1_ff;
  logic eraseSync2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseSync1_ff <= 1'b0;
      eraseSync2_ff <= 1'b0;
    end else begin
      eraseSync1_ff <= eraseAllReqPin;
      eraseSync2_ff <= eraseSync1_ff;
    end
  end

  // Configuration registers
  reg8_t cfg_ff;
  reg8_t errCfg_ff;
  reg8_t irqMask_ff;
  reg8_t nxt_cfg;
  assign nxt_cfg = wrCfg ? (hwdata[7:0] & `CFG_WR_MASK) : cfg_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= `RST_FLASH_CONFIG;
      errCfg_ff <= `RST_ERR_IRQ_CONFIG;
      irqMask_ff <= `RST_IRQ_MASK;
    end else begin
      // Force bits change only on software write
      cfg_ff <= nxt_cfg;
      if (wrErrCfg) errCfg_ff <= hwdata[7:0] & `ERRCFG_WR_MASK;
      if (wrIrqMask) irqMask_ff <= {5'h00, hwdata[2:0]};
    end
  end
  wire cmdDoneIe = cfg_ff[`BIT_CMD_DONE_IRQ_EN];
  wire ignoreSf = cfg_ff[`BIT_IGNORE_SF];
  wire forceDf = cfg_ff[`BIT_FORCE_DF];
  wire forceSf = cfg_ff[`BIT_FORCE_SF];
  wire sfIe = errCfg_ff[`BIT_SF_IRQ_EN];
  wire dfIe = errCfg_ff[`BIT_DF_IRQ_EN];
  wire [7:0] wrByte = hwdata[7:0];
  property p_cfg_wr;
    @(posedge clk) disable iff (!rst_n)
    wrCfg |=> cfg_ff == ($past(wrByte) & `CFG_WR_MASK);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("cfg write lost");
  property p_errcfg_wr;
    @(posedge clk) disable iff (!rst_n)
    wrErrCfg |=> errCfg_ff == ($past(wrByte) & `ERRCFG_WR_MASK);
  endproperty
  a_errcfg_wr: assert property (p_errcfg_wr)
    else $error("error cfg write lost");
  property p_cfg_hold;
    @(posedge clk) disable iff (!rst_n)
    !wrCfg |=> $stable(cfg_ff);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("cfg changed without write");
  property p_fsf_hold;
    @(posedge clk) disable iff (!rst_n)
    (forceSf & ~wrCfg) |=> forceSf;
  endproperty
  a_fsf_hold: assert property (p_fsf_hold)
    else $error("single force lost");

  // Command done flag and simple command timer
  logic cmdDone_ff;
  logic [7:0] cmdCnt_ff;
  logic eraseReq_ff;
  logic eraseBusy;
  logic eraseDone;
  logic eraseUnsec;
  wire launch = wrStat & hwdata[`BIT_CMD_DONE] & cmdDone_ff;
  // Erase-all accepted only while no command runs
  wire eraseStart = eraseSync2_ff & cmdDone_ff & ~eraseReq_ff & ~launch;
  wire cmdEnd = (cmdCnt_ff == 8'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdDone_ff <= 1'b1;
      cmdCnt_ff <= 8'h00;
    end else if (launch) begin
      cmdDone_ff <= 1'b0;
      cmdCnt_ff <= `CMD_TIME_CYCLES;
    end else if (eraseStart) begin
      cmdDone_ff <= 1'b0;
    end else begin
      if (cmdCnt_ff != 8'h00) cmdCnt_ff <= cmdCnt_ff - 8'h01;
      if (cmdEnd | eraseDone) cmdDone_ff <= 1'b1;
    end
  end
  assign cmdBusy = ~cmdDone_ff;
  property p_cmd_end;
    @(posedge clk) disable iff (!rst_n)
    launch |-> ##17 cmdDone_ff;
  endproperty
  a_cmd_end: assert property (p_cmd_end)
    else $error("command did not finish");

  // Erase-all request status, hardware only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) eraseReq_ff <= 1'b0;
    else if (eraseStart) eraseReq_ff <= 1'b1;
    else if (eraseDone) eraseReq_ff <= 1'b0;
  end
  property p_erase_ro;
    @(posedge clk) disable iff (!rst_n)
    (wrCfg & ~eraseStart & ~eraseDone) |=> $stable(eraseReq_ff);
  endproperty
  a_erase_ro: assert property (p_erase_ro)
    else $error("erase status written");
  property p_erase_src;
    @(posedge clk) disable iff (!rst_n)
    $rose(eraseReq_ff) |-> $past(eraseStart);
  endproperty
  a_erase_src: assert property (p_erase_src)
    else $error("erase status set without request");

  erase_all_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .start(eraseStart),
    .busy(eraseBusy),
    .progSecurity(securityProgram),
    .setUnsecure(eraseUnsec),
    .done(eraseDone)
  );

  // Live security field; secured until unsecure step runs
  logic [1:0] sec_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sec_ff <= 2'b01;
    else if (eraseUnsec) sec_ff <= 2'b10;
  end
  assign securityStateField = sec_ff;
  property p_erase_len;
    @(posedge clk) disable iff (!rst_n)
    eraseStart |-> ##25 eraseDone;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase sequence length");
  property p_unsec_prog;
    @(posedge clk) disable iff (!rst_n)
    eraseUnsec |-> $past(securityProgram);
  endproperty
  a_unsec_prog: assert property (p_unsec_prog)
    else $error("unsecure before program");

  // Fault flags
  wire sfSet = arrayRead &
    ((singleFaultDet & ~ignoreSf) | forceSf);
  wire dfSet = arrayRead & (doubleFaultDet | forceDf);
  logic sfFlag;
  logic dfFlag;
  sticky_flag u_sf (
    .clk(clk),
    .rst_n(rst_n),
    .setEv(sfSet),
    .clrEv(wrErrFlags & hwdata[`BIT_SF_FLAG]),
    .flag(sfFlag)
  );
  sticky_flag u_df (
    .clk(clk),
    .rst_n(rst_n),
    .setEv(dfSet),
    .clrEv(wrErrFlags & hwdata[`BIT_DF_FLAG]),
    .flag(dfFlag)
  );

  property p_sf_real;
    @(posedge clk) disable iff (!rst_n)
    (arrayRead & singleFaultDet & ~ignoreSf) |=> sfFlag;
  endproperty
  a_sf_real: assert property (p_sf_real)
    else $error("single fault not reported");
  property p_sf_force;
    @(posedge clk) disable iff (!rst_n)
    (arrayRead & forceSf) |=> sfFlag;
  endproperty
  a_sf_force: assert property (p_sf_force)
    else $error("single fault not forced");
  property p_sf_idle;
    @(posedge clk) disable iff (!rst_n)
    (~sfFlag & ~sfSet) |=> ~sfFlag;
  endproperty
  a_sf_idle: assert property (p_sf_idle)
    else $error("single flag set without read");
  property p_df_idle;
    @(posedge clk) disable iff (!rst_n)
    (~dfFlag & ~dfSet) |=> ~dfFlag;
  endproperty
  a_df_idle: assert property (p_df_idle)
    else $error("double flag set without read");
  property p_sf_clr;
    @(posedge clk) disable iff (!rst_n)
    (wrErrFlags & wrByte[`BIT_SF_FLAG] & ~sfSet) |=> ~sfFlag;
  endproperty
  a_sf_clr: assert property (p_sf_clr)
    else $error("single flag not cleared");
  property p_df_clr;
    @(posedge clk) disable iff (!rst_n)
    (wrErrFlags & wrByte[`BIT_DF_FLAG] & ~dfSet) |=> ~dfFlag;
  endproperty
  a_df_clr: assert property (p_df_clr)
    else $error("double flag not cleared");
  // Level requests
  assign cmdDoneIrq = cmdDone_ff & cmdDoneIe;
  assign singleFaultIrq = sfFlag & sfIe;
  assign doubleFaultIrq = dfFlag & dfIe;

  // Sticky event status, write one to clear
  logic [2:0] evStat_ff;
  logic cmdDoneQ_ff;
  wire [2:0] evSet = {dfSet, sfSet, cmdDone_ff & ~cmdDoneQ_ff};
  wire [2:0] evClr = wrIrqStat ? hwdata[2:0] : 3'b000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evStat_ff <= 3'b000;
      cmdDoneQ_ff <= 1'b1;
    end else begin
      evStat_ff <= evSet | (evStat_ff & ~evClr);
      cmdDoneQ_ff <= cmdDone_ff;
    end
  end
  assign irq = |(evStat_ff & irqMask_ff[2:0]);

  // Read mux
  reg8_t cfgRd;
  assign cfgRd = cfg_ff | (eraseReq_ff ? 8'h20 : 8'h00);
  wire [7:0] rdSel =
    hit(addr_ff, `OFS_FLASH_CONFIG) ? cfgRd :
    hit(addr_ff, `OFS_ERR_IRQ_CONFIG) ? errCfg_ff :
    hit(addr_ff, `OFS_FLASH_STATUS) ? {cmdDone_ff, 4'h0, eraseBusy, 2'b00} :
    hit(addr_ff, `OFS_ERROR_FLAGS) ? {6'h00, dfFlag, sfFlag} :
    hit(addr_ff, `OFS_IRQ_STATUS) ? {5'h00, evStat_ff} :
    hit(addr_ff, `OFS_IRQ_MASK) ? irqMask_ff : 8'h00;
  assign hrdata = rdPend_ff ? {24'h000000, rdSel} : 32'h00000000;

  property p_cfg_ro;
    @(posedge clk) disable iff (!rst_n)
    wrCfg |=> ((cfg_ff & 8'h6c) == 8'h00);
  endproperty
  a_cfg_ro: assert property (p_cfg_ro)
    else $error("cfg reserved set");
  property p_force_hold;
    @(posedge clk) disable iff (!rst_n)
    (forceDf & ~wrCfg) |=> forceDf;
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("force lost");
  property p_df_force;
    @(posedge clk) disable iff (!rst_n)
    (arrayRead & forceDf) |=> dfFlag;
  endproperty
  a_df_force: assert property (p_df_force)
    else $error("df not forced");
  property p_sf_ign;
    @(posedge clk) disable iff (!rst_n)
    (~sfFlag & arrayRead & ignoreSf & ~forceSf) |=> ~sfFlag;
  endproperty
  a_sf_ign: assert property (p_sf_ign)
    else $error("sf not ignored");
  property p_erase_set;
    @(posedge clk) disable iff (!rst_n)
    eraseStart |=> eraseReq_ff & ~cmdDone_ff;
  endproperty
  a_erase_set: assert property (p_erase_set)
    else $error("erase no set");
  property p_erase_clr;
    @(posedge clk) disable iff (!rst_n)
    eraseDone |=> ~eraseReq_ff && sec_ff == 2'b10;
  endproperty
  a_erase_clr: assert property (p_erase_clr)
    else $error("erase no clr");
  property p_cc_irq;
    @(posedge clk) disable iff (!rst_n)
    cmdDoneIrq == (cmdDone_ff && cfg_ff[7]);
  endproperty
  a_cc_irq: assert property (p_cc_irq)
    else $error("cc irq bad");
  property p_launch;
    @(posedge clk) disable iff (!rst_n)
    launch |=> ~cmdDone_ff [*8];
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch bad");
endmodule : flash_config_error_ctrl

/* core/flash_cfg_params.svh */
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH
`define OFS_FLASH_CONFIG 12'h000
`define OFS_ERR_IRQ_CONFIG 12'h004
`define OFS_FLASH_STATUS 12'h008
`define OFS_ERROR_FLAGS 12'h00c
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014
`define OFS_CMD_CTRL 12'h018
`define BIT_CMD_DONE_IRQ_EN 7
`define BIT_ERASE_ALL_REQ 5
`define BIT_IGNORE_SF 4
`define BIT_FORCE_DF 1
`define BIT_FORCE_SF 0
`define BIT_DF_IRQ_EN 1
`define BIT_SF_IRQ_EN 0
`define BIT_CMD_DONE 7
`define BIT_DF_FLAG 1
`define BIT_SF_FLAG 0
`define CFG_WR_MASK 8'h93
`define ERRCFG_WR_MASK 8'h03
`define RST_FLASH_CONFIG 8'h00
`define RST_ERR_IRQ_CONFIG 8'h00
`define RST_IRQ_MASK 8'h00
`define CMD_TIME_CYCLES 8'h10
`define ERASE_STEP_CYCLES 8'h08
`endif

/* core/flash_cfg_pkg.sv */
package flash_cfg_pkg;
  typedef enum logic [2:0] {
    ERA_IDLE = 3'b000,
    ERA_ERASE = 3'b001,
    ERA_VERIFY = 3'b010,
    ERA_PROG_SEC = 3'b011,
    ERA_UNSECURE = 3'b100
  } erase_state_t;
  typedef logic [7:0] reg8_t;
endpackage : flash_cfg_pkg

/* core/sticky_flag.sv */
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic setEv,
  input wire logic clrEv,
  output logic flag
);
  logic flag_ff;
  logic nxt_flag;
  // Set beats clear so a same-cycle event is kept
  assign nxt_flag = setEv | (flag_ff & ~clrEv);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flag_ff <= 1'b0;
    else flag_ff <= nxt_flag;
  end
  assign flag = flag_ff;
endmodule : sticky_flag

/* core/erase_all_seq.sv */
`timescale 1ns/1ps
`include "flash_cfg_params.svh"
module erase_all_seq
  import flash_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic progSecurity,
  output logic setUnsecure,
  output logic done
);
  import flash_cfg_pkg::*;
  erase_state_t state_ff;
  erase_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  wire stepEnd = (cnt_ff == `ERASE_STEP_CYCLES - 8'h01);
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = stepEnd ? 8'h00 : cnt_ff + 8'h01;
    unique case (state_ff)
      ERA_IDLE: begin
        nxt_cnt = 8'h00;
        if (start) nxt_state = ERA_ERASE;
      end
      ERA_ERASE: if (stepEnd) nxt_state = ERA_VERIFY;
      ERA_VERIFY: if (stepEnd) nxt_state = ERA_PROG_SEC;
      ERA_PROG_SEC: if (stepEnd) nxt_state = ERA_UNSECURE;
      ERA_UNSECURE: begin
        nxt_cnt = 8'h00;
        nxt_state = ERA_IDLE;
      end
      default: begin
        nxt_cnt = 8'h00;
        nxt_state = ERA_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ERA_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end
  // Erase, verify, program security byte, then unsecure
  assign busy = (state_ff != ERA_IDLE);
  assign progSecurity = (state_ff == ERA_PROG_SEC) & stepEnd;
  assign setUnsecure = (state_ff == ERA_UNSECURE);
  assign done = (state_ff == ERA_UNSECURE);
endmodule : erase_all_seq

/* tb/array_read_src.sv */
`timescale 1ns/1ps
module array_read_src (
  input wire logic clk,
  output logic arrayRead,
  output logic singleFaultDet,
  output logic doubleFaultDet
);
  initial begin
    arrayRead = 1'b0;
    singleFaultDet = 1'b1;
    doubleFaultDet = 1'b1;
  end

  // One array read per call; detect lines only mean something with it
  task automatic readOnce(input logic sf, input logic df);
    @(posedge clk);
    arrayRead <= 1'b1;
    singleFaultDet <= sf;
    doubleFaultDet <= df;
    @(posedge clk);
    arrayRead <= 1'b0;
    // Released lines show the inverse so stale values never help
    singleFaultDet <= ~sf;
    doubleFaultDet <= ~df;
  endtask : readOnce
endmodule : array_read_src

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "flash_cfg_params.svh"
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); \
  end \
end
module testbench;
  import flash_cfg_pkg::*;
  logic clk, rst_n, hsel, hwrite, eraseAllReqPin;
  logic sawProg = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, securityStateField;
  logic [2:0] hsize;
  logic hreadyout, hresp, cmdDoneIrq, singleFaultIrq, doubleFaultIrq;
  logic irq, securityProgram, cmdBusy, arrayRead, sfDet, dfDet;
  int num_errors = 0;
  int compares = 0;

  flash_config_error_ctrl DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .eraseAllReqPin(eraseAllReqPin),
    .arrayRead(arrayRead), .singleFaultDet(sfDet),
    .doubleFaultDet(dfDet), .cmdDoneIrq(cmdDoneIrq),
    .singleFaultIrq(singleFaultIrq), .doubleFaultIrq(doubleFaultIrq),
    .irq(irq), .securityStateField(securityStateField),
    .securityProgram(securityProgram), .cmdBusy(cmdBusy));
  array_read_src src (.clk(clk), .arrayRead(arrayRead),
    .singleFaultDet(sfDet), .doubleFaultDet(dfDet));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulse is a single cycle, so latch it for the end-of-erase check
  always @(posedge clk) if (securityProgram === 1'b1) sawProg <= 1'b1;

  // Entered just after a rising edge; returns at the edge ending the data phase
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(a, 1'b1, wd, rdv);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000, rdv);
    `CHK("register", exp, rdv)
  endtask : rchk

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    #(40 * 5000);
    num_errors++;
    stop_test;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    eraseAllReqPin = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(`OFS_FLASH_CONFIG, 32'h00000000);
    rchk(`OFS_FLASH_STATUS, 32'h00000080);
    rchk(12'h100, 32'h00000000);
    `CHK("security", 2'b01, securityStateField)
    $display("reset values done");
    wr(`OFS_FLASH_CONFIG, 32'hffffffff);
    rchk(`OFS_FLASH_CONFIG, 32'h00000093);
    `CHK("cmd irq", 1'b1, cmdDoneIrq)
    wr(`OFS_FLASH_CONFIG, 32'h00000000);
    // Write lands at the edge the task returns on; look one cycle later
    @(posedge clk);
    `CHK("cmd irq off", 1'b0, cmdDoneIrq)
    wr(`OFS_ERR_IRQ_CONFIG, 32'hffffffff);
    rchk(`OFS_ERR_IRQ_CONFIG, 32'h00000003);
    $display("access kinds done");
    // Command launch and the done event through status and mask
    wr(`OFS_FLASH_STATUS, 32'h00000080);
    rchk(`OFS_FLASH_STATUS, 32'h00000000);
    repeat (20) @(posedge clk);
    rchk(`OFS_FLASH_STATUS, 32'h00000080);
    rchk(`OFS_IRQ_STATUS, 32'h00000001);
    `CHK("irq masked", 1'b0, irq)
    wr(`OFS_IRQ_MASK, 32'h00000001);
    @(posedge clk);
    `CHK("irq open", 1'b1, irq)
    wr(`OFS_IRQ_STATUS, 32'h00000001);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("command test done");
    wr(`OFS_FLASH_CONFIG, 32'h00000003);
    src.readOnce(1'b0, 1'b0);
    settle;
    rchk(`OFS_ERROR_FLAGS, 32'h00000003);
    `CHK("sf irq", 1'b1, singleFaultIrq)
    `CHK("df irq", 1'b1, doubleFaultIrq)
    rchk(`OFS_FLASH_CONFIG, 32'h00000003);
    wr(`OFS_ERR_IRQ_CONFIG, 32'h00000002);
    @(posedge clk);
    `CHK("sf irq gated", 1'b0, singleFaultIrq)
    wr(`OFS_ERROR_FLAGS, 32'h00000003);
    rchk(`OFS_ERROR_FLAGS, 32'h00000000);
    `CHK("df irq gone", 1'b0, doubleFaultIrq)
    $display("forced fault test done");
    wr(`OFS_ERR_IRQ_CONFIG, 32'h00000001);
    wr(`OFS_FLASH_CONFIG, 32'h00000010);
    src.readOnce(1'b1, 1'b0);
    settle;
    rchk(`OFS_ERROR_FLAGS, 32'h00000000);
    `CHK("sf irq ignored", 1'b0, singleFaultIrq)
    wr(`OFS_FLASH_CONFIG, 32'h00000000);
    src.readOnce(1'b1, 1'b1);
    settle;
    rchk(`OFS_ERROR_FLAGS, 32'h00000003);
    wr(`OFS_ERROR_FLAGS, 32'h00000003);
    $display("real fault test done");
    eraseAllReqPin <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(`OFS_FLASH_STATUS, 32'h00000004);
    `CHK("busy", 1'b1, cmdBusy)
    `CHK("resp", 1'b0, hresp)
    rchk(`OFS_FLASH_CONFIG, 32'h00000020);
    eraseAllReqPin <= 1'b0;
    // Poll with a bound rather than trusting the step lengths
    for (int i = 0; i < 40 && rdv[5] !== 1'b0; i++)
      xfer(`OFS_FLASH_CONFIG, 1'b0, 32'h00000000, rdv);
    `CHK("erase status", 32'h00000000, rdv)
    `CHK("sec prog", 1'b1, sawProg)
    `CHK("unsecure", 2'b10, securityStateField)
    $display("erase all test done");
    stop_test;
  end
endmodule : testbench
